// ---- logic/ebcs_pkg.sv ----
// package for the external bus cycle sequencer
// assumes a 25 MHz system clock and AXI4-Lite register access
package ebcs_pkg;
  // register byte offsets
  localparam logic [7:0] TIMING_CONFIG_OFS = 8'h00;
  localparam logic [7:0] ADDRESS_OFS = 8'h04;
  localparam logic [7:0] WRITE_DATA_OFS = 8'h08;
  localparam logic [7:0] COMMAND_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] READ_DATA_OFS = 8'h14;
  // chip_select_timing_config field positions
  localparam int AB_LSB = 0;
  localparam int AB_EXT_LSB = 1;
  localparam int C_LSB = 3;
  localparam int D_LSB = 5;
  localparam int E_LSB = 6;
  localparam int F_LSB = 11;
  localparam int READY_EN_BIT = 13;
  localparam int READY_POL_BIT = 14;
  localparam int READY_ASYNC_BIT = 15;
  localparam int CS_COUNT = 4;
  localparam logic [31:0] TIMING_RESET = 32'h0000_0000;
  // command fields
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_CS_LSB = 1;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b000,
    PH_AB = 3'b001,
    PH_C = 3'b010,
    PH_D = 3'b011,
    PH_E = 3'b100,
    PH_WAIT = 3'b101,
    PH_F = 3'b110
  } ebcs_phase_e;
endpackage

// ---- logic/ebcs_sequencer.sv ----
// external bus cycle sequencer with AXI4-Lite register access
// assumes readyPin asynchronous to mclk; external bus pins drive pads directly
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ebcs_sequencer
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic busReferenceClock,
  output logic busReferenceClockFastDrive,
  output logic [23:0] busAddress,
  output logic [15:0] busDataOut,
  output logic busDataOe,
  input wire logic [15:0] busDataIn,
  output logic [3:0] chipSelectN,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic addressLatchEnable,
  input wire logic readyPin
);
  // ****************************************
  // register file
  // ****************************************
  logic [31:0] timingConfig [ebcs_pkg::CS_COUNT];
  logic [23:0] addressReg;
  logic [15:0] writeDataReg;
  logic [15:0] readDataReg;
  logic startPulse;
  logic cmdWrite;
  logic [1:0] cmdCs;
  logic [1:0] lastCs;
  logic busy;
  logic haveAw, haveW;
  logic [7:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  ebcs_pkg::ebcs_phase_e phase;
  ebcs_pkg::ebcs_phase_e next_phase;
  logic [5:0] next_count;
  logic endAccess;
  logic [5:0] count;
  logic [31:0] cfg;
  logic [1:0] readySync;
  logic readyAsyncStage;
  logic readyActive;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a == ebcs_pkg::TIMING_CONFIG_OFS || a == ebcs_pkg::ADDRESS_OFS || a == ebcs_pkg::WRITE_DATA_OFS
      || a == ebcs_pkg::COMMAND_OFS || a == ebcs_pkg::STATUS_OFS || a == ebcs_pkg::READ_DATA_OFS;
  endfunction

  assign awready = !haveAw && !bvalid;
  assign wready = !haveW && !bvalid;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      haveAw <= 1'b0;
      haveW <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
      bvalid <= 1'b0;
      bresp <= ebcs_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        haveAw <= 1'b1;
        awAddrHeld <= awaddr;
      end
      if (wvalid && wready)
      begin
        haveW <= 1'b1;
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
      end
      if (haveAw && haveW)
      begin
        haveAw <= 1'b0;
        haveW <= 1'b0;
        bvalid <= 1'b1;
        bresp <= known(awAddrHeld) ? ebcs_pkg::RESP_OKAY : ebcs_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // register writes; timing written to the entry named by command cs field
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < ebcs_pkg::CS_COUNT; i++)
        timingConfig[i] <= ebcs_pkg::TIMING_RESET;
      addressReg <= 24'h000000;
      writeDataReg <= 16'h0000;
      cmdWrite <= 1'b0;
      cmdCs <= 2'h0;
      startPulse <= 1'b0;
    end
    else
    begin
      startPulse <= 1'b0;
      if (haveAw && haveW)
      begin
        case (awAddrHeld)
          ebcs_pkg::TIMING_CONFIG_OFS:
            timingConfig[cmdCs] <= merge(timingConfig[cmdCs], wDataHeld, wStrbHeld);
          ebcs_pkg::ADDRESS_OFS:
            addressReg <= 24'(merge({8'h00, addressReg}, wDataHeld, wStrbHeld));
          ebcs_pkg::WRITE_DATA_OFS:
            writeDataReg <= 16'(merge({16'h0000, writeDataReg}, wDataHeld, wStrbHeld));
          ebcs_pkg::COMMAND_OFS:
            // command ignored while busy, running cycle keeps its fields
            if (!busy)
            begin
              cmdWrite <= wDataHeld[ebcs_pkg::CMD_WRITE_BIT];
              cmdCs <= wDataHeld[ebcs_pkg::CMD_CS_LSB +: 2];
              startPulse <= wStrbHeld[0];
            end
          default:
          begin
          end
        endcase
      end
    end
  end

  assign arready = !rvalid;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= ebcs_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp <= known(araddr) ? ebcs_pkg::RESP_OKAY : ebcs_pkg::RESP_SLVERR;
      case (araddr)
        ebcs_pkg::TIMING_CONFIG_OFS: rdata <= timingConfig[cmdCs];
        ebcs_pkg::ADDRESS_OFS: rdata <= {8'h00, addressReg};
        ebcs_pkg::WRITE_DATA_OFS: rdata <= {16'h0000, writeDataReg};
        ebcs_pkg::COMMAND_OFS: rdata <= {29'h0, cmdCs, cmdWrite};
        ebcs_pkg::STATUS_OFS: rdata <= {29'h0, phase};
        ebcs_pkg::READ_DATA_OFS: rdata <= {16'h0000, readDataReg};
        default: rdata <= 32'h0000_0000;
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // ****************************************
  // ready input
  // ****************************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      readySync <= 2'b00;
      readyAsyncStage <= 1'b0;
    end
    else
    begin
      readySync <= {readySync[0], readyPin};
      readyAsyncStage <= readySync[1];
    end
  end
  always_comb
  begin
    readyActive = (cfg[ebcs_pkg::READY_ASYNC_BIT] ? readyAsyncStage : readySync[1])
      ^ !cfg[ebcs_pkg::READY_POL_BIT];
  end

  // ****************************************
  // phase sequencer
  // ****************************************
  assign cfg = timingConfig[cmdCs];
  assign busy = phase != ebcs_pkg::PH_IDLE;
  assign busReferenceClock = mclk;
  assign busReferenceClockFastDrive = 1'b1;

  function automatic logic [5:0] len(input ebcs_pkg::ebcs_phase_e p, input logic [31:0] c, input logic winChange);
    case (p)
      ebcs_pkg::PH_AB: len = 6'(c[ebcs_pkg::AB_LSB]) + 6'h01
        + (winChange ? 6'(c[ebcs_pkg::AB_EXT_LSB +: 2]) : 6'h00);
      ebcs_pkg::PH_C: len = 6'(c[ebcs_pkg::C_LSB +: 2]);
      ebcs_pkg::PH_D: len = 6'(c[ebcs_pkg::D_LSB]);
      ebcs_pkg::PH_E: len = 6'(c[ebcs_pkg::E_LSB +: 5]) + 6'h01;
      ebcs_pkg::PH_F: len = 6'(c[ebcs_pkg::F_LSB +: 2]);
      default: len = 6'h00;
    endcase
  endfunction

  // next phase with nonzero length after p
  function automatic ebcs_pkg::ebcs_phase_e follow(input ebcs_pkg::ebcs_phase_e p, input logic [31:0] c);
    if (p == ebcs_pkg::PH_AB && len(ebcs_pkg::PH_C, c, 1'b0) != 6'h00)
      return ebcs_pkg::PH_C;
    if ((p == ebcs_pkg::PH_AB || p == ebcs_pkg::PH_C) && len(ebcs_pkg::PH_D, c, 1'b0) != 6'h00)
      return ebcs_pkg::PH_D;
    if (p == ebcs_pkg::PH_AB || p == ebcs_pkg::PH_C || p == ebcs_pkg::PH_D)
      return ebcs_pkg::PH_E;
    if ((p == ebcs_pkg::PH_E || p == ebcs_pkg::PH_WAIT) && len(ebcs_pkg::PH_F, c, 1'b0) != 6'h00)
      return ebcs_pkg::PH_F;
    return ebcs_pkg::PH_IDLE;
  endfunction

  function automatic logic inAccess(input ebcs_pkg::ebcs_phase_e p);
    return p == ebcs_pkg::PH_E || p == ebcs_pkg::PH_WAIT;
  endfunction

  assign endAccess = ((phase == ebcs_pkg::PH_E && count == 6'h01) || phase == ebcs_pkg::PH_WAIT)
    && (!cfg[ebcs_pkg::READY_EN_BIT] || readyActive);
  always_comb
  begin
    next_phase = phase;
    next_count = count;
    case (phase)
      ebcs_pkg::PH_IDLE:
        if (startPulse)
        begin
          next_phase = ebcs_pkg::PH_AB;
          next_count = len(ebcs_pkg::PH_AB, cfg, cmdCs != lastCs);
        end
      ebcs_pkg::PH_E, ebcs_pkg::PH_WAIT:
        if (endAccess)
        begin
          next_phase = follow(phase, cfg);
          next_count = len(next_phase, cfg, 1'b0);
        end
        else if (phase == ebcs_pkg::PH_E && count == 6'h01)
          next_phase = ebcs_pkg::PH_WAIT;
        else if (phase == ebcs_pkg::PH_E)
          next_count = count - 6'h01;
      ebcs_pkg::PH_AB, ebcs_pkg::PH_C, ebcs_pkg::PH_D, ebcs_pkg::PH_F:
        if (count <= 6'h01)
        begin
          next_phase = follow(phase, cfg);
          next_count = len(next_phase, cfg, 1'b0);
        end
        else
          next_count = count - 6'h01;
      default: next_phase = ebcs_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase <= ebcs_pkg::PH_IDLE;
      count <= 6'h00;
      lastCs <= 2'h0;
    end
    else
    begin
      phase <= next_phase;
      count <= next_count;
      if (phase == ebcs_pkg::PH_IDLE && startPulse)
        lastCs <= cmdCs;
    end
  end

  // ****************************************
  // bus pins
  // ****************************************
  // pins follow the phase being entered, so they line up with it
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      readDataReg <= 16'h0000;
      busAddress <= 24'h000000;
      busDataOut <= 16'h0000;
      busDataOe <= 1'b0;
      chipSelectN <= 4'hf;
      readStrobeN <= 1'b1;
      writeStrobeN <= 1'b1;
      addressLatchEnable <= 1'b0;
    end
    else
    begin
      if (phase == ebcs_pkg::PH_IDLE && startPulse)
      begin
        busAddress <= addressReg;
        busDataOut <= writeDataReg;
      end
      addressLatchEnable <= next_phase == ebcs_pkg::PH_AB;
      chipSelectN <= next_phase == ebcs_pkg::PH_IDLE ? 4'hf : ~(4'h1 << cmdCs);
      busDataOe <= cmdWrite && (next_phase == ebcs_pkg::PH_D || inAccess(next_phase)
        || next_phase == ebcs_pkg::PH_F);
      readStrobeN <= !(!cmdWrite && inAccess(next_phase));
      writeStrobeN <= !(cmdWrite && inAccess(next_phase));
      if (!cmdWrite && endAccess)
        readDataReg <= busDataIn;
    end
  end
endmodule
`default_nettype wire

// ---- verification/ebcs_memory_model.sv ----
// memory with ready handshake on the parallel bus
// assumes the reference clock from the sequencer
`timescale 1ns/10ps
`default_nettype none
module ebcs_memory_model
(
  input wire logic busReferenceClock,
  input wire logic [23:0] busAddress,
  input wire logic [15:0] busDataOut,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [7:0] readyDelay,
  input wire logic readyActiveHigh,
  output logic [15:0] busDataIn,
  output logic readyPin
);
  logic [15:0] mem [16];
  logic [15:0] lastData = 16'h0;
  logic [7:0] lowCnt = 8'h0;
  always @(posedge busReferenceClock)
  begin
    if (!writeStrobeN) mem[busAddress[3:0]] <= busDataOut;
    if (!readStrobeN) lastData <= mem[busAddress[3:0]];
    lowCnt <= (readStrobeN && writeStrobeN) ? 8'h0 : lowCnt + 8'h1;
  end
  // released bus shows the inverse of the last word
  assign busDataIn = readStrobeN ? ~lastData : mem[busAddress[3:0]];
  assign readyPin = (lowCnt >= readyDelay && !(readStrobeN && writeStrobeN)) ? readyActiveHigh : ~readyActiveHigh;
endmodule
`default_nettype wire

// ---- verification/ebcs_properties.sv ----
// pin checker for the bus cycle sequencer
// assumes a bind onto ebcs_sequencer
`timescale 1ns/10ps
`default_nettype none
module ebcs_properties
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic busReferenceClock,
  input wire logic busReferenceClockFastDrive,
  input wire logic busDataOe,
  input wire logic [23:0] busAddress,
  input wire logic [3:0] chipSelectN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic addressLatchEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence accessStart;
    $fell(readStrobeN) || $fell(writeStrobeN);
  endsequence
  sequence setupPhase;
    addressLatchEnable && readStrobeN && writeStrobeN;
  endsequence
  AST_REF_CLOCK: assert property (@(negedge mclk) busReferenceClock && busReferenceClockFastDrive)
    else $error("reference clock not on pin");
  AST_CS_ONE: assert property ($onehot0(~chipSelectN))
    else $error("several chip selects active");
  AST_ACCESS_SELECTED: assert property (accessStart |-> chipSelectN != 4'hf && !addressLatchEnable)
    else $error("access without setup");
  AST_ONE_STROBE: assert property (readStrobeN || writeStrobeN)
    else $error("both strobes active");
  AST_SETUP_FIRST: assert property ($rose(addressLatchEnable) |-> setupPhase)
    else $error("strobe during address setup");
  AST_READ_ADDR: assert property (!readStrobeN && $past(!readStrobeN) |-> $stable(busAddress))
    else $error("address moved during read");
  AST_READ_FREE: assert property (!readStrobeN |-> !busDataOe)
    else $error("data driven during read");
  AST_WRITE_DRIVEN: assert property (!writeStrobeN |-> busDataOe)
    else $error("write data not driven");
endmodule
bind ebcs_sequencer ebcs_properties propCheck (.mclk, .resetn, .busReferenceClock, .busReferenceClockFastDrive,
  .busDataOe, .busAddress, .chipSelectN, .readStrobeN, .writeStrobeN, .addressLatchEnable);
`default_nettype wire

// ---- verification/external_bus_cycle_sequencer_test.sv ----
// self-checking bench for the bus cycle sequencer
// assumes the memory model on the far side
`timescale 1ns/10ps
`default_nettype none
module external_bus_cycle_sequencer_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, readyDelay = 8'h04;
  logic [31:0] wdata = 32'h0, mismatches = 32'h0, nCompared = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, readyActiveHigh = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busDataOe, readStrobeN, writeStrobeN;
  logic addressLatchEnable, readyPin, busReferenceClock;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, preC, accC, postC, d, accSync;
  logic [23:0] busAddress;
  logic [15:0] busDataOut, busDataIn;
  logic [3:0] chipSelectN;
  always #20 mclk = ~mclk;
  ebcs_sequencer dut (.mclk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .busReferenceClock,
    .busReferenceClockFastDrive(), .busAddress, .busDataOut, .busDataOe, .busDataIn, .chipSelectN,
    .readStrobeN, .writeStrobeN, .addressLatchEnable, .readyPin);
  ebcs_memory_model far (.busReferenceClock, .busAddress, .busDataOut, .readStrobeN, .writeStrobeN,
    .readyDelay, .readyActiveHigh, .busDataIn, .readyPin);
  // ****************************************
  // phase lengths seen at the pins
  // ****************************************
  logic csIdle = 1'b1;
  // counts selected cycles before, during and after the strobe
  always @(posedge mclk)
  begin
    csIdle <= chipSelectN == 4'hf;
    if (chipSelectN != 4'hf)
    begin
      if (csIdle)
      begin
        preC <= 32'h1;
        accC <= 32'h0;
        postC <= 32'h0;
      end
      else if (!readStrobeN || !writeStrobeN) accC <= accC + 32'h1;
      else if (accC == 32'h0) preC <= preC + 32'h1;
      else postC <= postC + 32'h1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge mclk);
      if (aw && awready)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic runCycle(input logic [31:0] cmd);
    logic [31:0] st;
    axiWrite(ebcs_pkg::COMMAND_OFS, cmd);
    st = 32'h1;
    while (st[2:0] !== 3'h0) axiRead(ebcs_pkg::STATUS_OFS, st, r);
    repeat (2) @(posedge mclk);
  endtask
  task automatic phases(input logic [31:0] p, input logic [31:0] a, input logic [31:0] f);
    check(preC, p);
    check(accC, a);
    check(postC, f);
  endtask
  task automatic endSim;
    $display("compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 32'h0 && nCompared > 32'h0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    endSim;
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    axiRead(ebcs_pkg::TIMING_CONFIG_OFS, d, r);
    check(d, ebcs_pkg::TIMING_RESET);
    axiRead(8'h18, d, r);
    check({d[31:2], r}, {30'h0, ebcs_pkg::RESP_SLVERR});
    $display("register test done");
    axiWrite(ebcs_pkg::ADDRESS_OFS, 32'h5);
    axiWrite(ebcs_pkg::WRITE_DATA_OFS, 32'hbeef);
    runCycle(32'h1);
    phases(32'h1, 32'h1, 32'h0);
    axiWrite(ebcs_pkg::TIMING_CONFIG_OFS, 32'h1fff);
    axiWrite(ebcs_pkg::ADDRESS_OFS, 32'h6);
    axiWrite(ebcs_pkg::WRITE_DATA_OFS, 32'h1234);
    runCycle(32'h1);
    phases(32'h6, 32'h20, 32'h3);
    $display("write test done");
    axiWrite(ebcs_pkg::ADDRESS_OFS, 32'h5);
    runCycle(32'h2);
    phases(32'h1, 32'h1, 32'h0);
    axiRead(ebcs_pkg::READ_DATA_OFS, d, r);
    check(d, 32'hbeef);
    axiWrite(ebcs_pkg::ADDRESS_OFS, 32'h6);
    runCycle(32'h0);
    phases(32'h9, 32'h20, 32'h3);
    axiRead(ebcs_pkg::READ_DATA_OFS, d, r);
    check(d, 32'h1234);
    $display("read test done");
    axiWrite(ebcs_pkg::TIMING_CONFIG_OFS, 32'h2000);
    runCycle(32'h0);
    accSync = accC;
    check({31'h0, accSync > 32'h4}, 32'h1);
    axiWrite(ebcs_pkg::TIMING_CONFIG_OFS, 32'ha000);
    runCycle(32'h0);
    check(accC, accSync + 32'h1);
    readyActiveHigh <= 1'b1;
    axiWrite(ebcs_pkg::TIMING_CONFIG_OFS, 32'h6000);
    runCycle(32'h0);
    check(accC, accSync);
    $display("ready test done");
    endSim;
  end
endmodule
`default_nettype wire
